// file: rtl/scc_context.sv
// per-connection transmit context of the segmentation engine
`timescale 1ns/100ps
module scc_context (
  input  wire logic                          sys_clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          init_in,
  input  wire logic                          oam_payload_type_low_in,
  input  wire logic                          oam_loss_priority_value_in,
  input  wire logic                          oam_priority_select_in,
  input  wire logic                          hdr_clp_in,
  input  wire logic [1:0]                    oam_interval_code_in,
  input  wire logic                          oam_sent_in,
  input  wire logic                          blocking_mode_in,
  input  wire logic [7:0]                    block_size_in,
  input  wire logic [4:0]                    packets_per_frame_in,
  input  wire logic                          pcr_terminate_in,
  input  wire logic                          pcr_delay_in,
  input  wire logic                          pid_only_in,
  input  wire logic                          stats_en_in,
  input  wire logic                          block_en_in,
  input  wire logic                          count_packets_in,
  input  wire logic                          cell_in,
  input  wire logic                          cell_clp_in,
  input  wire logic                          cell_last_in,
  input  wire logic                          ts_start_in,
  input  wire logic                          ts_has_pcr_in,
  input  wire logic [scc_pkg::PCR_W-1:0]     ts_pcr_in,
  input  wire logic [17:0]                   ts_pcr_low_in,
  input  wire logic [scc_pkg::PID_W-1:0]     ts_pid_in,
  input  wire logic [scc_pkg::PCR_W-1:0]     time_base_in,
  input  wire logic                          brm_write_in,
  input  wire logic [31:0]                   brm_addr_in,
  input  wire logic                          brm_sent_in,
  input  wire logic                          enq_in,
  input  wire logic                          deq_in,
  input  wire logic [15:0]                   byte_len_in,
  input  wire logic [scc_pkg::THRESH_W-1:0]  threshold1_in,
  input  wire logic [scc_pkg::THRESH_W-1:0]  threshold2_in,
  input  wire logic [scc_pkg::POOL_W-1:0]    base_pool_in,
  input  wire logic [scc_pkg::POOL_W-1:0]    alternate_pool1_in,
  input  wire logic [scc_pkg::POOL_W-1:0]    alternate_pool2_in,
  input  wire logic                          timeslot_in,
  input  wire logic [1:0]                    timer_type_in,
  input  wire logic [scc_pkg::TMR_W-1:0]     timer_period_in,
  input  wire logic [scc_pkg::TMR_W-1:0]     timer_stamp_in,
  input  wire logic [31:0]                   dma_desc_addr_in,
  input  wire logic                          frm_sent_in,
  input  wire logic                          brm_rx_in,
  input  wire logic [scc_pkg::RM_W-1:0]      missing_rm_limit_in,
  input  wire logic [scc_pkg::RM_W-1:0]      cutoff_decrease_exp_in,
  output logic                               oam_insert_out,
  output logic                               oam_hdr_pti_low_out,
  output logic                               oam_hdr_clp_out,
  output logic [7:0]                         oam_seq_out,
  output logic                               oam_sent_flag_out,
  output logic [7:0]                         blocking_count_out,
  output logic [4:0]                         ts_index_out,
  output logic                               frame_end_out,
  output logic [1:0]                         prev_clock_ref_high_out,
  output logic [15:0]                        prev_clock_ref_low_out,
  output logic                               clock_ref_present_out,
  output logic                               prev_pcr_seen_out,
  output logic                               stream_id_valid_out,
  output logic                               stream_id_match_out,
  output logic                               clock_ref_check_out,
  output logic                               cell_delay_out,
  output logic [scc_pkg::PCR_W-1:0]          clock_ref_offset_out,
  output logic                               clock_ref_offset_valid_out,
  output logic [31:0]                        brm_addr_out,
  output logic [scc_pkg::STAT_W-1:0]         user_cell_total_out,
  output logic                               user_cell_total_wrap_out,
  output logic [scc_pkg::STAT_W-1:0]         user_cell_high_priority_total_out,
  output logic                               user_cell_hp_wrap_out,
  output logic [scc_pkg::POOL_W-1:0]         pool_id_out,
  output logic                               dma_queue_out,
  output logic [31:0]                        dma_desc_out,
  output logic                               frm_allowed_out,
  output logic [scc_pkg::RM_W-1:0]           missing_rm_counter_out
);
  import scc_pkg::*;

  typedef struct packed {
    logic [9:0]         oam_cnt;
    logic               oam_due;
    logic [7:0]         oam_seq;
    logic               oam_sent;
    logic               oam_pti;
    logic               oam_clp;
    logic [7:0]         blk;
    logic [4:0]         idx;
    logic               frame_end;
    logic [17:0]        pcr_low;
    logic               pcr_now;
    logic               pcr_prev;
    logic [PCR_W-1:0]   pcr_hold;
    logic [PID_W-1:0]   pid;
    logic               pid_valid;
    logic               pid_match;
    logic               chk;
    logic               delay;
    logic [PCR_W-1:0]   ofs;
    logic               ofs_valid;
    logic [31:0]        brm;
    logic [BYTES_W-1:0] bytes;
    logic [POOL_W-1:0]  pool;
    scc_tmr_st_t        tmr_st;
    logic [TMR_W-1:0]   tmr_cnt;
    logic [TMR_W-1:0]   slot;
    logic               dma_q;
    logic [31:0]        dma_desc;
    logic [RM_W-1:0]    missing_rm_counter;
    logic               frm_ok;
  } scc_ctx_t;

  scc_ctx_t s_q, s_d;
  logic [8:0] blk_sum;
  logic       pkt_done;
  logic       match_now;
  logic       stat_en;
  logic       hp_inc;

  // block progress, one step per segmented cell
  assign blk_sum   = {1'b0, s_q.blk} + {1'b0, WORDS_PER_CELL};
  assign pkt_done  = blk_sum >= {1'b0, block_size_in};
  assign match_now = s_q.pid_valid ? (ts_pid_in == s_q.pid) : 1'b1;
  // statistics gating
  assign stat_en   = stats_en_in | block_en_in;
  assign hp_inc    = count_packets_in ? cell_last_in : !cell_clp_in;

  // next context
  always_comb begin
    s_d           = s_q;
    s_d.oam_due   = 1'b0;
    s_d.frame_end = 1'b0;
    s_d.dma_q     = 1'b0;
    // oam header bits follow the context
    s_d.oam_pti = oam_payload_type_low_in;
    s_d.oam_clp = oam_priority_select_in ? oam_loss_priority_value_in
                                         : hdr_clp_in;
    if (init_in) begin
      s_d        = '0;
      s_d.pool   = base_pool_in;
      s_d.tmr_st = TM_ARMED;
      s_d.tmr_cnt = timer_period_in;
      s_d.missing_rm_counter   = missing_rm_limit_in;
      s_d.frm_ok = missing_rm_limit_in != MISSING_RM_COUNTER_RST;
    end else begin
      // one oam cell after each block of user cells
      if (cell_in && block_en_in) begin
        if (s_q.oam_cnt == OAM_LAST[oam_interval_code_in]) begin
          s_d.oam_cnt = '0;
          s_d.oam_due = 1'b1;
        end else begin
          s_d.oam_cnt = s_q.oam_cnt + 10'h001;
        end
      end
      if (oam_sent_in) begin
        s_d.oam_seq  = s_q.oam_seq + 8'h01;
        s_d.oam_sent = 1'b1;
      end
      // word count and packet index in blocking modes
      if (cell_in && blocking_mode_in) begin
        if (pkt_done) begin
          s_d.blk = 8'(blk_sum - {1'b0, block_size_in});
          if (s_q.idx + 5'h01 >= packets_per_frame_in) begin
            s_d.idx       = '0;
            s_d.frame_end = 1'b1;
          end else begin
            s_d.idx = s_q.idx + 5'h01;
          end
          if (pcr_terminate_in && s_q.pcr_now) begin
            s_d.idx       = '0;
            s_d.frame_end = 1'b1;
          end
          // decide a late clock reference packet
          if (pcr_delay_in && s_q.pcr_now
              && (s_q.pid_match || !pid_only_in)) begin
            s_d.chk = 1'b1;
          end
        end else begin
          s_d.blk = blk_sum[7:0];
        end
      end
      // check stays until the time base catches up
      if (s_q.chk) begin
        s_d.delay = (time_base_in + s_q.ofs) < s_q.pcr_hold;
        s_d.chk   = s_d.delay;
      end else begin
        s_d.delay = 1'b0;
      end
      // new transport stream packet
      if (ts_start_in) begin
        s_d.pcr_prev  = s_q.pcr_prev | s_q.pcr_now;
        s_d.pcr_now   = ts_has_pcr_in;
        s_d.pid_match = match_now;
        if (ts_has_pcr_in) begin
          s_d.pcr_low  = ts_pcr_low_in;
          s_d.pcr_hold = ts_pcr_in;
          if (!s_q.pid_valid) begin
            s_d.pid       = ts_pid_in;
            s_d.pid_valid = 1'b1;
          end
          if (!s_q.ofs_valid) begin
            s_d.ofs       = ts_pcr_in - time_base_in;
            s_d.ofs_valid = 1'b1;
          end
        end
      end
      // backward rm buffer address
      if (brm_sent_in) begin
        s_d.brm = '0;
      end else if (brm_write_in) begin
        s_d.brm = brm_addr_in;
      end
      // queued byte count and pool switching
      case ({enq_in, deq_in})
        2'b10: s_d.bytes = s_q.bytes + BYTES_W'(byte_len_in);
        2'b01: s_d.bytes = s_q.bytes - BYTES_W'(byte_len_in);
        default: s_d.bytes = s_q.bytes;
      endcase
      if (s_d.bytes[BYTES_W-1:THRESH_LSB] >= threshold2_in) begin
        s_d.pool = alternate_pool2_in;
      end else if (s_d.bytes[BYTES_W-1:THRESH_LSB] >= threshold1_in) begin
        s_d.pool = alternate_pool1_in;
      end else begin
        s_d.pool = base_pool_in;
      end
      // timer in timeslots
      if (timeslot_in) begin
        s_d.slot = s_q.slot + 16'h0001;
        unique case (s_q.tmr_st)
          TM_IDLE: s_d.tmr_st = TM_IDLE;
          TM_ARMED: begin
            if (timer_type_in[1] ? (s_q.slot == timer_stamp_in)
                                 : (s_q.tmr_cnt <= 16'h0001)) begin
              s_d.dma_q   = 1'b1;
              s_d.dma_desc = dma_desc_addr_in;
              s_d.tmr_cnt = timer_period_in;
              if (!timer_type_in[0]) begin
                s_d.tmr_st = TM_IDLE;
              end else if (timer_type_in[1]) begin
                s_d.tmr_cnt = timer_period_in;
                s_d.tmr_st  = TM_IDLE;
              end
            end else begin
              s_d.tmr_cnt = s_q.tmr_cnt - 16'h0001;
            end
          end
        endcase
      end
      // absolute periodic runs on the period after the stamp
      if (timer_type_in == TMR_ABS_PER && s_q.tmr_st == TM_IDLE
          && s_q.tmr_cnt != '0 && timeslot_in) begin
        if (s_q.tmr_cnt <= 16'h0001) begin
          s_d.dma_q   = 1'b1;
          s_d.dma_desc = dma_desc_addr_in;
          s_d.tmr_cnt = timer_period_in;
        end else begin
          s_d.tmr_cnt = s_q.tmr_cnt - 16'h0001;
        end
      end
      // forward rm limit, reload on backward rm
      if (brm_rx_in) begin
        s_d.missing_rm_counter = cutoff_decrease_exp_in;
      end else if (frm_sent_in && s_q.missing_rm_counter != MISSING_RM_COUNTER_RST) begin
        s_d.missing_rm_counter = s_q.missing_rm_counter - 8'h01;
      end
      s_d.frm_ok = s_d.missing_rm_counter != MISSING_RM_COUNTER_RST;
    end
  end

  // context register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q      <= '0;
      s_q.pool <= POOL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // statistics counters
  scc_wrap_cnt #(.W(STAT_W)) u_total (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .clear_in   (init_in),
    .inc_in     (cell_in && stat_en),
    .count_out  (user_cell_total_out),
    .wrap_out   (user_cell_total_wrap_out)
  );
  scc_wrap_cnt #(.W(STAT_W)) u_high_prio (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .clear_in   (init_in),
    .inc_in     (cell_in && stat_en && hp_inc),
    .count_out  (user_cell_high_priority_total_out),
    .wrap_out   (user_cell_hp_wrap_out)
  );

  // outputs from the context register
  assign oam_insert_out             = s_q.oam_due;
  assign oam_hdr_pti_low_out        = s_q.oam_pti;
  assign oam_hdr_clp_out            = s_q.oam_clp;
  assign oam_seq_out                = s_q.oam_seq;
  assign oam_sent_flag_out          = s_q.oam_sent;
  assign blocking_count_out         = s_q.blk;
  assign ts_index_out               = s_q.idx;
  assign frame_end_out              = s_q.frame_end;
  assign prev_clock_ref_high_out    = s_q.pcr_low[17:16];
  assign prev_clock_ref_low_out     = s_q.pcr_low[15:0];
  assign clock_ref_present_out      = s_q.pcr_now;
  assign prev_pcr_seen_out          = s_q.pcr_prev;
  assign stream_id_valid_out        = s_q.pid_valid;
  assign stream_id_match_out        = s_q.pid_match;
  assign clock_ref_check_out        = s_q.chk;
  assign cell_delay_out             = s_q.delay;
  assign clock_ref_offset_out       = s_q.ofs;
  assign clock_ref_offset_valid_out = s_q.ofs_valid;
  assign brm_addr_out               = s_q.brm;
  assign pool_id_out                = s_q.pool;
  assign dma_queue_out              = s_q.dma_q;
  assign dma_desc_out               = s_q.dma_desc;
  assign frm_allowed_out            = s_q.frm_ok;
  assign missing_rm_counter_out     = s_q.missing_rm_counter;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_oam_pti_copy: assert property (
    !init_in |=> oam_hdr_pti_low_out == $past(oam_payload_type_low_in))
    else $error("oam pti low bit not copied");
  chk_oam_clp_src: assert property (
    !init_in && oam_priority_select_in
    |=> oam_hdr_clp_out == $past(oam_loss_priority_value_in))
    else $error("oam clp not from context value");
  chk_oam_block_end: assert property (
    !init_in && cell_in && block_en_in
    && s_q.oam_cnt == OAM_LAST[oam_interval_code_in]
    |=> oam_insert_out && s_q.oam_cnt == '0)
    else $error("oam cell not due at block end");
  chk_oam_seq_step: assert property (
    !init_in && oam_sent_in
    |=> oam_seq_out == 8'($past(oam_seq_out) + 8'h01) && oam_sent_flag_out)
    else $error("monitor sequence not advanced");
  chk_brm_clear: assert property (
    !init_in && brm_sent_in |=> brm_addr_out == '0)
    else $error("backward rm address not cleared");
  chk_offset_first: assert property (
    !init_in && ts_start_in && ts_has_pcr_in && !clock_ref_offset_valid_out
    |=> clock_ref_offset_valid_out
        && clock_ref_offset_out == $past(ts_pcr_in) - $past(time_base_in))
    else $error("clock reference offset not derived");
  chk_offset_hold: assert property (
    !init_in && clock_ref_offset_valid_out
    |=> $stable(clock_ref_offset_out))
    else $error("clock reference offset changed");
  chk_pid_lock: assert property (
    !init_in && ts_start_in && ts_has_pcr_in && !stream_id_valid_out
    ##1 !init_in && ts_start_in && ts_pid_in == $past(ts_pid_in)
    |=> stream_id_match_out)
    else $error("locked stream id not matched");
  chk_pool_high: assert property (
    !init_in && !enq_in && !deq_in
    && s_q.bytes[BYTES_W-1:THRESH_LSB] >= threshold2_in
    |=> pool_id_out == $past(alternate_pool2_in))
    else $error("pool not switched above threshold");
  chk_rm_reload: assert property (
    !init_in && brm_rx_in
    |=> missing_rm_counter_out == $past(cutoff_decrease_exp_in)
        && frm_allowed_out == (missing_rm_counter_out != MISSING_RM_COUNTER_RST))
    else $error("missing rm counter not reloaded");
  chk_timer_once: assert property (
    dma_queue_out && timer_type_in == TMR_REL_ONCE
    && $past(timer_type_in) == TMR_REL_ONCE
    |-> s_q.tmr_st == TM_IDLE)
    else $error("one shot timer re-armed");

  cov_oam_insert: cover property (oam_insert_out);
  cov_frame_end: cover property (frame_end_out ##1 !frame_end_out);
  cov_delay: cover property (clock_ref_check_out && cell_delay_out);
  cov_dma: cover property (dma_queue_out);
endmodule : scc_context

// file: rtl/scc_pkg.sv
// constants and types for the segmentation connection context
package scc_pkg;
  localparam logic [7:0]  WORDS_PER_CELL = 8'h0C;
  localparam logic [9:0]  OAM_LAST [4]   = '{10'h07F, 10'h0FF, 10'h1FF, 10'h3FF};
  localparam logic [7:0]  MPEG_BLOCK_SIZE = 8'h47;
  localparam int unsigned BYTES_W        = 32;
  localparam int unsigned THRESH_W       = 24;
  localparam int unsigned THRESH_LSB     = 8;
  localparam int unsigned STAT_W         = 32;
  localparam int unsigned PCR_W          = 36;
  localparam int unsigned PID_W          = 13;
  localparam int unsigned TMR_W          = 16;
  localparam int unsigned RM_W           = 8;
  localparam int unsigned POOL_W         = 4;
  localparam logic [3:0]  POOL_RST       = 4'h0;
  localparam logic [7:0]  MISSING_RM_COUNTER_RST       = 8'h00;
  typedef enum logic [1:0] {
    TMR_REL_ONCE = 2'b00,
    TMR_REL_PER  = 2'b01,
    TMR_ABS_ONCE = 2'b10,
    TMR_ABS_PER  = 2'b11
  } scc_tmr_type_t;
  typedef enum logic {
    TM_IDLE  = 1'b0,
    TM_ARMED = 1'b1
  } scc_tmr_st_t;
endpackage : scc_pkg

// file: rtl/scc_wrap_cnt.sv
// statistics counter with wrap event
`timescale 1ns/100ps
module scc_wrap_cnt #(
  parameter int W = 32
) (
  input  wire logic         sys_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         clear_in,
  input  wire logic         inc_in,
  output logic [W-1:0]      count_out,
  output logic              wrap_out
);
  import scc_pkg::*;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         wrap;
  } scc_cnt_st_t;
  scc_cnt_st_t s_q, s_d;

  // count up, pulse on roll over
  always_comb begin
    s_d      = s_q;
    s_d.wrap = 1'b0;
    if (clear_in) begin
      s_d.cnt = '0;
    end else if (inc_in) begin
      s_d.cnt  = s_q.cnt + 1'b1;
      s_d.wrap = &s_q.cnt;
    end
  end

  // state register
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_out = s_q.cnt;
  assign wrap_out  = s_q.wrap;

  chk_wrap_event: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    inc_in && !clear_in && (&count_out) |=> wrap_out && count_out == '0)
    else $error("counter wrap without event");
endmodule : scc_wrap_cnt

// file: test/scc_cell_src.sv
// cell source standing in for the segmentation side feeding user cells
`timescale 1ns/100ps
module scc_cell_src (
  input  wire logic        sys_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        start_in,
  input  wire logic [10:0] count_in,
  input  wire logic        clp_in,
  output logic             cell_out,
  output logic             cell_clp_out,
  output logic             busy_out
);
  logic [10:0] left_q;
  // one cell a cycle; the clp line toggles when idle so stale values never pass
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      left_q       <= 11'h000;
      cell_out     <= 1'b0;
      cell_clp_out <= 1'b0;
    end else if (start_in) begin
      left_q   <= count_in;
      cell_out <= 1'b0;
    end else begin
      cell_out     <= (left_q != 11'h000);
      cell_clp_out <= (left_q != 11'h000) ? clp_in : ~cell_clp_out;
      left_q       <= (left_q != 11'h000) ? left_q - 11'h001 : left_q;
    end
  end
  // busy until the last cell has left
  assign busy_out = (left_q != 11'h000) || cell_out;
endmodule : scc_cell_src

// file: test/tb_top.sv
// self-checking bench for the connection context
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module tb_top;
  import scc_pkg::*;
  logic sys_clk_in = 0, sys_rst_in = 1, init_in = 0, oam_payload_type_low_in = 0;
  logic oam_loss_priority_value_in = 0, oam_priority_select_in = 0, hdr_clp_in = 0;
  logic oam_sent_in = 0, blocking_mode_in = 0, pcr_terminate_in = 0, pcr_delay_in = 0;
  logic pid_only_in = 0, stats_en_in = 0, block_en_in = 0, count_packets_in = 0;
  logic cell_last_in = 0, ts_start_in = 0, ts_has_pcr_in = 0, brm_write_in = 0;
  logic brm_sent_in = 0, enq_in = 0, deq_in = 0, timeslot_in = 0, frm_sent_in = 0;
  logic brm_rx_in = 0, src_start = 0, src_clp = 0, cell_in, cell_clp_in, src_busy;
  logic [1:0] oam_interval_code_in = '0, timer_type_in = '0;
  logic [4:0] packets_per_frame_in = '0;
  logic [7:0] block_size_in = '0, missing_rm_limit_in = '0, cutoff_decrease_exp_in = '0;
  logic [10:0] src_n = '0;
  logic [12:0] ts_pid_in = '0;
  logic [15:0] byte_len_in = '0, timer_period_in = '0, timer_stamp_in = '0;
  logic [17:0] ts_pcr_low_in = '0;
  logic [23:0] threshold1_in = '0, threshold2_in = '0;
  logic [3:0] base_pool_in = '0, alternate_pool1_in = '0, alternate_pool2_in = '0;
  logic [31:0] brm_addr_in = '0, dma_desc_addr_in = '0;
  logic [35:0] ts_pcr_in = '0, time_base_in = '0;
  logic oam_insert_out, oam_hdr_pti_low_out, oam_hdr_clp_out, oam_sent_flag_out;
  logic frame_end_out, clock_ref_present_out, prev_pcr_seen_out, stream_id_valid_out;
  logic stream_id_match_out, clock_ref_check_out, cell_delay_out, dma_queue_out;
  logic clock_ref_offset_valid_out, user_cell_total_wrap_out, user_cell_hp_wrap_out;
  logic frm_allowed_out;
  logic [7:0] oam_seq_out, blocking_count_out, missing_rm_counter_out;
  logic [4:0] ts_index_out;
  logic [1:0] prev_clock_ref_high_out;
  logic [15:0] prev_clock_ref_low_out;
  logic [35:0] clock_ref_offset_out;
  logic [31:0] brm_addr_out, user_cell_total_out, user_cell_high_priority_total_out;
  logic [31:0] dma_desc_out;
  logic [3:0] pool_id_out;
  int mismatches = 0, n_compared = 0, n_oam = 0, n_dma = 0, n_fe = 0, n;
  scc_context dut (.*);
  scc_cell_src src (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .start_in(src_start),
    .count_in(src_n), .clp_in(src_clp), .cell_out(cell_in), .cell_clp_out(cell_clp_in),
    .busy_out(src_busy));
  // clock
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // count one-cycle output pulses
  always @(posedge sys_clk_in) begin
    if (oam_insert_out === 1'b1) n_oam++;
    if (dma_queue_out === 1'b1) n_dma++;
    if (frame_end_out === 1'b1) n_fe++;
  end
  task automatic tick;
    @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
    tick;
  endtask : pulse
  // send n cells through the source and wait until they are through
  task automatic cells(input int cnt, input logic clp);
    int i = 0;
    src_n = 11'(cnt);
    src_clp = clp;
    pulse(src_start);
    while (src_busy === 1'b1 && i < 2000) begin
      tick;
      i++;
    end
    repeat (3) tick;
  endtask : cells
  task automatic report(input string s);
    $display("test %s done, mismatches so far %0d", s, mismatches);
  endtask : report
  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // watchdog
  initial begin
    #100000;
    mismatches++;
    results;
  end
  // main sequence
  initial begin
    repeat (12) @(posedge sys_clk_in);
    #1;
    sys_rst_in = 0;
    `CHK(pool_id_out, 4'h0)
    `CHK(brm_addr_out, 32'h0)
    report("reset");
    block_en_in = 1;
    blocking_mode_in = 1;
    block_size_in = MPEG_BLOCK_SIZE;
    packets_per_frame_in = 5'h04;
    oam_payload_type_low_in = 1;
    oam_priority_select_in = 1;
    hdr_clp_in = 1;
    for (int c = 0; c < 4; c++) begin
      oam_interval_code_in = 2'(c);
      n = 128 << c;
      pulse(init_in);
      n_oam = 0;
      n_fe = 0;
      cells(n - 1, 1'b0);
      `CHK(n_oam, 0)
      cells(1, 1'b1);
      `CHK(n_oam, 1)
      `CHK(oam_hdr_pti_low_out, 1'b1)
      `CHK(oam_hdr_clp_out, 1'b0)
      `CHK(user_cell_total_out, 32'(n))
      `CHK(user_cell_high_priority_total_out, 32'(n - 1))
      `CHK(blocking_count_out, 8'((n * 12) % 71))
      `CHK(ts_index_out, 5'(((n * 12) / 71) % 4))
      `CHK(n_fe, ((n * 12) / 71) / 4)
      `CHK(user_cell_total_wrap_out, 1'b0)
      `CHK(user_cell_hp_wrap_out, 1'b0)
    end
    pulse(oam_sent_in);
    `CHK(oam_seq_out, 8'h01)
    `CHK(oam_sent_flag_out, 1'b1)
    report("oam and statistics");
    stats_en_in = 1;
    time_base_in = 36'h0_0000_1000;
    ts_pcr_in = 36'h1_2345_6789;
    ts_pcr_low_in = 18'h2_ABCD;
    ts_pid_in = 13'h0123;
    ts_has_pcr_in = 1;
    ts_start_in = 1;
    tick;
    `CHK(prev_clock_ref_high_out, 2'h2)
    `CHK(prev_clock_ref_low_out, 16'hABCD)
    `CHK(clock_ref_present_out, 1'b1)
    `CHK(clock_ref_offset_out, ts_pcr_in - time_base_in)
    `CHK(clock_ref_offset_valid_out, 1'b1)
    `CHK(stream_id_valid_out, 1'b1)
    ts_has_pcr_in = 0;
    tick;
    ts_start_in = 0;
    `CHK(stream_id_match_out, 1'b1)
    `CHK(prev_pcr_seen_out, 1'b1)
    pcr_delay_in = 1;
    pcr_terminate_in = 1;
    pid_only_in = 1;
    count_packets_in = 1;
    cell_last_in = 1;
    ts_pcr_in = 36'h1_2345_6799;
    ts_has_pcr_in = 1;
    tick;
    pulse(ts_start_in);
    cells(6, 1'b1);
    `CHK(clock_ref_check_out, 1'b1)
    `CHK(cell_delay_out, 1'b1)
    `CHK(ts_index_out, 5'h00)
    `CHK(user_cell_high_priority_total_out, 32'd1029)
    time_base_in = 36'h0_0000_1010;
    tick;
    `CHK(cell_delay_out, 1'b0)
    `CHK(clock_ref_check_out, 1'b0)
    report("clock reference");
    missing_rm_limit_in = 8'h03;
    pulse(init_in);
    `CHK(missing_rm_counter_out, 8'h03)
    brm_addr_in = 32'hA5A5_0040;
    pulse(brm_write_in);
    `CHK(brm_addr_out, 32'hA5A5_0040)
    pulse(brm_sent_in);
    `CHK(brm_addr_out, 32'h0)
    cutoff_decrease_exp_in = 8'h05;
    pulse(brm_rx_in);
    `CHK(missing_rm_counter_out, 8'h05)
    `CHK(frm_allowed_out, 1'b1)
    pulse(frm_sent_in);
    `CHK(missing_rm_counter_out, 8'h04)
    report("rm cells");
    threshold1_in = 24'h000001;
    threshold2_in = 24'h000004;
    base_pool_in = 4'h1;
    alternate_pool1_in = 4'h2;
    alternate_pool2_in = 4'h3;
    byte_len_in = 16'h0100;
    pulse(enq_in);
    `CHK(pool_id_out, 4'h2)
    byte_len_in = 16'h0300;
    pulse(enq_in);
    `CHK(pool_id_out, 4'h3)
    byte_len_in = 16'h0400;
    pulse(deq_in);
    `CHK(pool_id_out, 4'h1)
    report("pools");
    timer_period_in = 16'h0003;
    timer_stamp_in = 16'h0002;
    dma_desc_addr_in = 32'h0000_8000;
    for (int t = 0; t < 4; t++) begin
      timer_type_in = 2'(t);
      pulse(init_in);
      n_dma = 0;
      repeat (7) pulse(timeslot_in);
      `CHK(n_dma, 1 + t % 2)
    end
    `CHK(dma_desc_out, 32'h0000_8000)
    report("timers");
    results;
  end
endmodule : tb_top
